// ### epb_params.svh
// Constants for the external program-memory bus sequencer
`ifndef EPB_PARAMS_SVH
`define EPB_PARAMS_SVH

`define EPB_CLKS_PER_MCYCLE    3'h4
`define EPB_PH_ADDR            2'h0
`define EPB_PH_LATCH           2'h1
`define EPB_PH_STROBE          2'h2
`define EPB_PH_LAST            2'h3
`define EPB_RESET_MCYCLES      4'h2
`define EPB_RESET_HOLD_CLKS    (`EPB_RESET_MCYCLES * 4'(`EPB_CLKS_PER_MCYCLE))
`define EPB_INT_CODE_TOP_BIT   4'hf
`define EPB_ADDR_RESET         16'h0000
`define EPB_BYTE_RESET         8'h00

`endif

// ### epb_pkg.sv
// Types for the external program-memory bus sequencer
package epb_pkg;

    typedef logic [1:0] epb_phase_t;

    typedef enum logic {
        EPB_KIND_FETCH,
        EPB_KIND_TABLE
    } epb_kind_e;

    typedef struct packed {
        logic       s1;
        logic       s2;
        epb_phase_t phase;
        logic [3:0] hold_cnt;
        logic       pin_reset;
    } epb_cyc_s;

    typedef struct packed {
        logic       sel_s1;
        logic       sel_s2;
        logic [7:0] ad_s1;
        logic [7:0] ad_s2;
        logic       act;
        logic       act_ext;
        epb_kind_e  act_kind;
        logic [15:0] addr;
        logic       pend;
        logic       pend_ext;
        epb_kind_e  pend_kind;
        logic       rsp_valid;
        logic       rsp_ext;
        epb_kind_e  rsp_kind;
        logic [7:0] rsp_data;
        logic [7:0] int_data;
        logic       ale;
        logic       strobe_n;
        logic [7:0] ad_out;
        logic       ad_oe;
        logic [7:0] hi_out;
        logic       hi_oe;
        logic       int_rd;
    } epb_seq_s;

endpackage

// ### epb_cycle_if.sv
// Machine-cycle timing shared between the cycle generator and the sequencer
`timescale 1ns/100ps
interface epb_cycle_if;
    epb_pkg::epb_phase_t phase;
    logic                pin_reset;

    modport gen (output phase, output pin_reset);
    modport seq (input phase, input pin_reset);
endinterface

// ### epb_cycle_gen.sv
// Machine-cycle phase counter and reset-pin qualifier
`timescale 1ns/100ps
`include "epb_params.svh"
module epb_cycle_gen (
    input  wire logic    clk_i,
    input  wire logic    rst_n_i,
    input  wire logic    reset_pin_i,
    epb_cycle_if.gen     cyc
);
    epb_pkg::epb_cyc_s q, d;

    always_comb begin
        d = q;
        d.s1 = reset_pin_i;
        d.s2 = q.s1;
        d.phase = q.phase + 2'h1;
        if (!q.s2) begin
            d.hold_cnt = 4'h0;
            d.pin_reset = 1'b0;
        end else if (q.hold_cnt < `EPB_RESET_HOLD_CLKS - 4'h1) begin
            d.hold_cnt = q.hold_cnt + 4'h1;
        end else begin
            d.pin_reset = 1'b1;
        end
        if (d.pin_reset) begin
            d.phase = `EPB_PH_ADDR;
        end
    end

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end

    assign cyc.phase     = q.phase;
    assign cyc.pin_reset = q.pin_reset;
endmodule // epb_cycle_gen

// ### epb_bus_top.sv
// External program-memory bus sequencer: code fetch and table read over the multiplexed bus
`timescale 1ns/100ps
`include "epb_params.svh"
// Summary of operation
// - Select low forces every fetch external
// - Select high, low 32 KB stays internal
// - Program-store strobe low on external reads
// - No strobe pulse on internal code access
// - Address-latch pulse on every external access
// - Low address then data share port
// - Upper address on second port throughout
// - Reset pin held two cycles resets
// - Four clocks make one machine cycle
module epb_bus_top (
    input  wire logic        SYS_CLK_I,
    input  wire logic        RESET_N_I,
    input  wire logic        RESET_PIN_I,
    input  wire logic        EXT_FETCH_SELECT_N_I,
    input  wire logic        REQ_VALID_I,
    input  wire logic        REQ_CODE_TABLE_READ_I,
    input  wire logic [15:0] REQ_ADDR_I,
    output logic             REQ_READY_O,
    output logic             RSP_VALID_O,
    output logic [7:0]       RSP_DATA_O,
    output logic             RSP_EXTERNAL_O,
    output logic             RSP_CODE_TABLE_READ_O,
    output logic             INT_RD_O,
    output logic [14:0]      INT_ADDR_O,
    input  wire logic [7:0]  INT_DATA_I,
    output logic             ADDR_LATCH_O,
    output logic             PROGRAM_STORE_STROBE_N_O,
    input  wire logic [7:0]  AD_LOW_I,
    output logic [7:0]       AD_LOW_O,
    output logic             AD_LOW_OE_O,
    output logic [7:0]       ADDR_HIGH_O,
    output logic             ADDR_HIGH_OE_O,
    output logic             DEVICE_IN_RESET_O
);
    epb_cycle_if cyc ();

    epb_cycle_gen u_cycle_gen (
        .clk_i       (SYS_CLK_I),
        .rst_n_i     (RESET_N_I),
        .reset_pin_i (RESET_PIN_I),
        .cyc         (cyc)
    );

    epb_pkg::epb_seq_s q, d;
    logic              accept;
    logic              go_ext;

    // An access goes external when the select pin is low or the address is past internal code
    function automatic logic is_external(input logic sel_high, input logic [15:0] addr);
        return !sel_high || addr[`EPB_INT_CODE_TOP_BIT];
    endfunction

    // Requests are taken in the last phase and run through the following machine cycle
    assign accept = REQ_VALID_I && (cyc.phase == `EPB_PH_LAST) && !cyc.pin_reset;
    assign go_ext = is_external(q.sel_s2, REQ_ADDR_I);

    always_comb begin
        d = q;
        d.sel_s1 = EXT_FETCH_SELECT_N_I;
        d.sel_s2 = q.sel_s1;
        d.ad_s1 = AD_LOW_I;
        d.ad_s2 = q.ad_s1;
        d.rsp_valid = 1'b0;
        case (cyc.phase)
            `EPB_PH_ADDR: begin
                d.ale = 1'b0;
                if (q.pend) begin
                    d.rsp_valid = 1'b1;
                    d.rsp_ext = q.pend_ext;
                    d.rsp_kind = q.pend_kind;
                    d.rsp_data = q.pend_ext ? q.ad_s2 : q.int_data;
                    d.pend = 1'b0;
                end
            end
            `EPB_PH_LATCH: begin
                if (q.act && q.act_ext) begin
                    d.ad_oe = 1'b0;
                    d.strobe_n = 1'b0;
                end
            end
            `EPB_PH_STROBE: begin
                d.strobe_n = q.strobe_n;
            end
            `EPB_PH_LAST: begin
                d.strobe_n = 1'b1;
                d.hi_oe = 1'b0;
                d.ad_oe = 1'b0;
                d.int_rd = 1'b0;
                // Internal byte taken while its own address still stands
                if (q.act && !q.act_ext) begin
                    d.int_data = INT_DATA_I;
                end
                d.pend = q.act;
                d.pend_ext = q.act_ext;
                d.pend_kind = q.act_kind;
                d.act = accept;
                if (accept) begin
                    d.addr = REQ_ADDR_I;
                    d.act_ext = go_ext;
                    d.act_kind = REQ_CODE_TABLE_READ_I ? epb_pkg::EPB_KIND_TABLE : epb_pkg::EPB_KIND_FETCH;
                    if (go_ext) begin
                        d.ale = 1'b1;
                        d.ad_out = REQ_ADDR_I[7:0];
                        d.ad_oe = 1'b1;
                        d.hi_out = REQ_ADDR_I[15:8];
                        d.hi_oe = 1'b1;
                    end else begin
                        d.int_rd = 1'b1;
                    end
                end
            end
            default: begin
                d.strobe_n = 1'b1;
            end
        endcase
        if (cyc.pin_reset) begin
            d.act = 1'b0;
            d.pend = 1'b0;
            d.ale = 1'b0;
            d.strobe_n = 1'b1;
            d.ad_oe = 1'b0;
            d.hi_oe = 1'b0;
            d.int_rd = 1'b0;
            d.rsp_valid = 1'b0;
        end
    end

    always_ff @(posedge SYS_CLK_I or negedge RESET_N_I) begin
        if (!RESET_N_I) begin
            q <= '0;
            q.strobe_n <= 1'b1;
            q.sel_s1 <= 1'b1;
            q.sel_s2 <= 1'b1;
            q.addr <= `EPB_ADDR_RESET;
            q.rsp_data <= `EPB_BYTE_RESET;
        end else begin
            q <= d;
        end
    end

    assign REQ_READY_O              = (cyc.phase == `EPB_PH_LAST) && !cyc.pin_reset;
    assign RSP_VALID_O              = q.rsp_valid;
    assign RSP_DATA_O               = q.rsp_data;
    assign RSP_EXTERNAL_O           = q.rsp_ext;
    assign RSP_CODE_TABLE_READ_O    = (q.rsp_kind == epb_pkg::EPB_KIND_TABLE);
    assign INT_RD_O                 = q.int_rd;
    assign INT_ADDR_O               = q.addr[14:0];
    assign ADDR_LATCH_O             = q.ale;
    assign PROGRAM_STORE_STROBE_N_O = q.strobe_n;
    assign AD_LOW_O                 = q.ad_out;
    assign AD_LOW_OE_O              = q.ad_oe;
    assign ADDR_HIGH_O              = q.hi_out;
    assign ADDR_HIGH_OE_O           = q.hi_oe;
    assign DEVICE_IN_RESET_O        = cyc.pin_reset;
endmodule // epb_bus_top

// ### epb_bus_props.sv
// Checker for the program-memory bus sequencer
`timescale 1ns/100ps
module epb_bus_props (
    input wire logic        SYS_CLK_I,
    input wire logic        RESET_N_I,
    input wire logic        REQ_VALID_I,
    input wire logic [15:0] REQ_ADDR_I,
    input wire logic        REQ_READY_O,
    input wire logic        RSP_VALID_O,
    input wire logic        INT_RD_O,
    input wire logic [14:0] INT_ADDR_O,
    input wire logic        ADDR_LATCH_O,
    input wire logic        PROGRAM_STORE_STROBE_N_O,
    input wire logic [7:0]  AD_LOW_O,
    input wire logic        AD_LOW_OE_O,
    input wire logic [7:0]  ADDR_HIGH_O,
    input wire logic        ADDR_HIGH_OE_O,
    input wire logic        DEVICE_IN_RESET_O
);
    default clocking cb @(posedge SYS_CLK_I); endclocking
    default disable iff (!RESET_N_I);
    sequence s_take;
        REQ_VALID_I && REQ_READY_O;
    endsequence
    sequence s_strobe;
        !PROGRAM_STORE_STROBE_N_O [*2] ##1 PROGRAM_STORE_STROBE_N_O;
    endsequence
    chk_latch_then_strobe: assert property (ADDR_LATCH_O |-> ##2 s_strobe)
        else $error("strobe does not follow latch");
    chk_internal_quiet: assert property (INT_RD_O |-> PROGRAM_STORE_STROBE_N_O && !ADDR_LATCH_O)
        else $error("bus active on internal access");
    chk_strobe_port: assert property (!PROGRAM_STORE_STROBE_N_O |-> !AD_LOW_OE_O && ADDR_HIGH_OE_O)
        else $error("port not turned round");
    chk_low_addr_hold: assert property (ADDR_LATCH_O |=> AD_LOW_OE_O && $stable(AD_LOW_O) ##1 !AD_LOW_OE_O)
        else $error("low address not held");
    chk_high_addr_hold: assert property (ADDR_LATCH_O |=> ($stable(ADDR_HIGH_O) && ADDR_HIGH_OE_O) [*3])
        else $error("upper address not held");
    chk_upper_goes_ext: assert property (s_take ##0 REQ_ADDR_I[15] |=> ADDR_LATCH_O && ADDR_HIGH_O == 8'($past(REQ_ADDR_I) >> 8))
        else $error("upper range not external");
    chk_int_address: assert property (s_take |=> ADDR_LATCH_O || INT_ADDR_O == 15'($past(REQ_ADDR_I)))
        else $error("internal address wrong");
    chk_ready_frame: assert property (REQ_READY_O |=> !REQ_READY_O [*3])
        else $error("machine cycle not four clocks");
    chk_resp_time: assert property (s_take |-> ##6 RSP_VALID_O)
        else $error("response late");
    chk_pin_reset: assert property (DEVICE_IN_RESET_O |-> !REQ_READY_O && !ADDR_LATCH_O)
        else $error("activity in pin reset");
endmodule // epb_bus_props
bind epb_bus_top epb_bus_props u_props (.*);

// ### epb_rom_model.sv
// External program ROM with its address latch
`timescale 1ns/100ps
module epb_rom_model (
    input  wire logic       clk_i,
    input  wire logic       ale_i,
    input  wire logic       strobe_n_i,
    input  wire logic [7:0] ad_i,
    input  wire logic       ad_oe_i,
    input  wire logic [7:0] hi_i,
    output logic      [7:0] ad_bus_o
);
    logic [7:0] lo_q;
    logic [7:0] pat_q = 8'h00;
    always_latch if (ale_i) lo_q <= ad_i;
    // Released bus shows a moving pattern, never the old byte
    always @(posedge clk_i) pat_q <= pat_q + 8'h3b;
    always_comb begin
        if (ad_oe_i) ad_bus_o = ad_i;
        else if (!strobe_n_i) ad_bus_o = lo_q ^ hi_i ^ 8'h5a;
        else ad_bus_o = pat_q;
    end
endmodule // epb_rom_model

// ### tb_top.sv
// Self-checking bench for the program-memory bus sequencer
`timescale 1ns/100ps
module tb_top;
    logic SYS_CLK_I = 0, RESET_N_I = 0, RESET_PIN_I = 0, EXT_FETCH_SELECT_N_I = 1;
    logic REQ_VALID_I = 0, REQ_CODE_TABLE_READ_I = 0;
    logic [15:0] REQ_ADDR_I = 16'h0000;
    logic [7:0] INT_DATA_I, AD_LOW_I, RSP_DATA_O, AD_LOW_O, ADDR_HIGH_O;
    logic [14:0] INT_ADDR_O;
    logic REQ_READY_O, RSP_VALID_O, RSP_EXTERNAL_O, RSP_CODE_TABLE_READ_O, INT_RD_O, ADDR_LATCH_O;
    logic PROGRAM_STORE_STROBE_N_O, AD_LOW_OE_O, ADDR_HIGH_OE_O, DEVICE_IN_RESET_O;
    int n_mismatch = 0, n_tests = 0, seed = 56, cyc = 0;
    logic [9:0] expq[$];
    function automatic logic [7:0] rom_f(input logic [15:0] a);
        return a[7:0] ^ a[15:8] ^ 8'h5a;
    endfunction
    assign INT_DATA_I = ~rom_f({1'b0, INT_ADDR_O});
    epb_bus_top uut (.*);
    epb_rom_model rom (.clk_i(SYS_CLK_I), .ale_i(ADDR_LATCH_O), .strobe_n_i(PROGRAM_STORE_STROBE_N_O),
        .ad_i(AD_LOW_O), .ad_oe_i(AD_LOW_OE_O), .hi_i(ADDR_HIGH_O), .ad_bus_o(AD_LOW_I));
    initial forever #2 SYS_CLK_I = ~SYS_CLK_I;
    task automatic check(input logic c, input string m);
        n_tests++;
        if (c !== 1'b1) begin
            n_mismatch++;
            $display("[ERR] %0t %s", $time, m);
        end
    endtask
    task automatic req(input logic [15:0] a, input logic t);
        logic ext;
        REQ_VALID_I = 1;
        REQ_ADDR_I = a;
        REQ_CODE_TABLE_READ_I = t;
        while (REQ_READY_O !== 1'b1) begin
            @(posedge SYS_CLK_I);
            #1;
        end
        ext = !EXT_FETCH_SELECT_N_I || a[15];
        expq.push_back({ext, t, ext ? rom_f(a) : ~rom_f(a)});
        @(posedge SYS_CLK_I);
        #1;
    endtask
    task automatic print_verdict;
        $display("Checks %0d, mismatches %0d", n_tests, n_mismatch);
        if (n_mismatch == 0 && n_tests > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask
    always @(negedge SYS_CLK_I) if (RSP_VALID_O === 1'b1) begin
        check(expq.size() > 0, "unexpected response");
        if (expq.size() > 0) check({RSP_EXTERNAL_O, RSP_CODE_TABLE_READ_O, RSP_DATA_O} === expq.pop_front(), "bad response");
    end
    always @(posedge SYS_CLK_I) begin
        cyc++;
        if (cyc == 5000) begin
            n_mismatch++;
            print_verdict;
        end
    end
    initial begin
        repeat (10) @(posedge SYS_CLK_I);
        #1 RESET_N_I = 1;
        for (int b = 0; b < 6; b++) begin
            EXT_FETCH_SELECT_N_I = b[0];
            repeat (8) @(posedge SYS_CLK_I);
            #1;
            req(16'h7fff, 0);
            req(16'h8000, 1);
            repeat (20) req(16'($random(seed)), 1'($random(seed)));
            REQ_VALID_I = 0;
            repeat (12) @(posedge SYS_CLK_I);
            #1;
        end
        RESET_PIN_I = 1;
        repeat (3) @(posedge SYS_CLK_I);
        #1 RESET_PIN_I = 0;
        repeat (12) @(posedge SYS_CLK_I);
        #1 check(DEVICE_IN_RESET_O === 1'b0, "short pulse reset");
        RESET_PIN_I = 1;
        repeat (14) @(posedge SYS_CLK_I);
        #1 check(DEVICE_IN_RESET_O === 1'b1 && REQ_READY_O === 1'b0, "no pin reset");
        RESET_PIN_I = 0;
        repeat (8) @(posedge SYS_CLK_I);
        #1 req(16'h1234, 0);
        REQ_VALID_I = 0;
        repeat (12) @(posedge SYS_CLK_I);
        #1 check(expq.size() == 0, "missing response");
        print_verdict;
    end
endmodule // tb_top
